// file: src/bsx_defines.svh
// Purpose: constants for the bit set / test-skip execution block
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data address
// Notes: one value per macro
`ifndef BSX_DEFINES_SVH
`define BSX_DEFINES_SVH
`define BSX_OP_SET 4'h8
`define BSX_OP_TSC 4'hb
`define BSX_OP_MSB 15
`define BSX_OP_LSB 12
`define BSX_BIT_MSB 11
`define BSX_BIT_LSB 9
`define BSX_A_POS 8
`define BSX_F_MSB 7
`define BSX_F_LSB 0
`define BSX_ACC_SPLIT 8'h80
`define BSX_ACC_HI_BANK 4'hf
`define BSX_ACC_LO_BANK 4'h0
`endif

// file: src/bsx_regfile.sv
// Purpose: small data memory for the bit execution block
// Assumes: one read and one write port, read data registered
// Notes: write takes effect at the clock edge
`timescale 1ns/1ps
module bsx_regfile #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic clock,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_reg
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock) begin
        rdata_reg <= mem[raddr];
    end
endmodule

// file: src/bsx_pkg.sv
// Purpose: types for the bit set / test-skip execution block
// Assumes: nothing beyond the defines header
// Notes: phase and state codes are one-hot
package bsx_pkg;
    typedef enum logic [3:0] {
        BSX_Q1 = 4'h1,
        BSX_Q2 = 4'h2,
        BSX_Q3 = 4'h4,
        BSX_Q4 = 4'h8
    } bsx_phase_t;

    typedef enum logic [2:0] {
        BSX_EXEC = 3'h1,
        BSX_NOP1 = 3'h2,
        BSX_NOP2 = 3'h4
    } bsx_state_t;

    typedef struct packed {
        logic [15:0] word;
        logic two_word;
    } bsx_fetch_t;

    typedef struct packed {
        logic set_register_bit;
        logic test_bit_skip_when_clear;
        logic [2:0] bitpos;
        logic bank_sel;
        logic [7:0] faddr;
    } bsx_dec_t;
endpackage

// file: src/bsx_exec.sv
// Purpose: executes set_register_bit and test_bit_skip_when_clear
// Assumes: one instruction cycle is four clocks (phases); fetch is held in q1 of each cycle
`timescale 1ns/1ps
`include "bsx_defines.svh"
module bsx_exec
    import bsx_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire bsx_fetch_t fetch,
    input wire logic [3:0] bank_pointer,
    output logic [3:0] phase_reg,
    output logic skip_reg,
    output logic nop_cycle_reg,
    output logic status_we_reg,
    output logic [AW-1:0] addr_reg,
    output logic [7:0] wdata_reg,
    output logic mem_we_reg
);
    bsx_phase_t phase_q;
    bsx_state_t state_reg;
    bsx_dec_t dec_reg;
    logic [7:0] rdata;
    logic [AW-1:0] addr_next;
    logic [AW-1:0] raddr_next;

    function automatic bsx_dec_t decode(input logic [15:0] w);
        bsx_dec_t d;
        d.set_register_bit = w[`BSX_OP_MSB:`BSX_OP_LSB] == `BSX_OP_SET;
        d.test_bit_skip_when_clear = w[`BSX_OP_MSB:`BSX_OP_LSB] == `BSX_OP_TSC;
        d.bitpos = w[`BSX_BIT_MSB:`BSX_BIT_LSB];
        d.bank_sel = w[`BSX_A_POS];
        d.faddr = w[`BSX_F_MSB:`BSX_F_LSB];
        return d;
    endfunction

    // access bank: low half in bank 0, high half in the top bank (sfr area)
    function automatic logic [AW-1:0] eff_addr(input logic a, input logic [7:0] f,
                                                input logic [3:0] bp);
        logic [3:0] bank;
        bank = bp;
        if (!a) begin
            bank = (f < `BSX_ACC_SPLIT) ? `BSX_ACC_LO_BANK : `BSX_ACC_HI_BANK;
        end
        return AW'({bank, f});
    endfunction

    // phase ring advances every clock
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_q <= BSX_Q1;
        end else begin
            case (phase_q)
                BSX_Q1: phase_q <= BSX_Q2;
                BSX_Q2: phase_q <= BSX_Q3;
                BSX_Q3: phase_q <= BSX_Q4;
                BSX_Q4: phase_q <= BSX_Q1;
                default: phase_q <= BSX_Q1;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_reg <= 4'h1;
        end else begin
            case (phase_q)
                BSX_Q1: phase_reg <= 4'h2;
                BSX_Q2: phase_reg <= 4'h4;
                BSX_Q3: phase_reg <= 4'h8;
                default: phase_reg <= 4'h1;
            endcase
        end
    end

    // decode latch: the word is only consumed in q1 of an executing cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dec_reg <= '0;
        end else if (phase_q == BSX_Q1 && state_reg == BSX_EXEC) begin
            dec_reg <= decode(fetch.word);
        end
    end

    assign raddr_next = eff_addr(dec_reg.bank_sel, dec_reg.faddr, bank_pointer);

    bsx_regfile #(.AW(AW), .DW(8)) u_mem (
        .clock(clock),
        .we(mem_we_reg),
        .waddr(addr_reg),
        .wdata(wdata_reg),
        .raddr(raddr_next),
        .rdata_reg(rdata)
    );

    always_comb begin
        addr_next = addr_reg;
        if (phase_q == BSX_Q2) begin
            addr_next = raddr_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_reg <= '0;
        end else begin
            addr_reg <= addr_next;
        end
    end

    // read data from q2 address lands in q3; modify in q3, write in q4
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_we_reg <= 1'b0;
            wdata_reg <= 8'h00;
        end else begin
            mem_we_reg <= phase_q == BSX_Q3 && state_reg == BSX_EXEC
                && dec_reg.set_register_bit;
            if (phase_q == BSX_Q3) begin
                wdata_reg <= rdata | (8'h01 << dec_reg.bitpos);
            end
        end
    end

    // neither instruction ever writes flags
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status_we_reg <= 1'b0;
        end else begin
            status_we_reg <= 1'b0;
        end
    end

    // skip sequencing; state changes at the end of q4
    // the tested bit must be known: an unknown bit leaves the state undefined
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= BSX_EXEC;
            skip_reg <= 1'b0;
        end else begin
            if (phase_q == BSX_Q3 && state_reg == BSX_EXEC) begin
                skip_reg <= dec_reg.test_bit_skip_when_clear
                    && !rdata[dec_reg.bitpos];
            end else if (phase_q == BSX_Q4) begin
                skip_reg <= 1'b0;
            end
            if (phase_q == BSX_Q4) begin
                case (state_reg)
                    BSX_EXEC: state_reg <= skip_reg ? BSX_NOP1 : BSX_EXEC;
                    BSX_NOP1: state_reg <= fetch.two_word ? BSX_NOP2 : BSX_EXEC;
                    BSX_NOP2: state_reg <= BSX_EXEC;
                    default: state_reg <= BSX_EXEC;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            nop_cycle_reg <= 1'b0;
        end else if (phase_q == BSX_Q4) begin
            case (state_reg)
                BSX_EXEC: nop_cycle_reg <= skip_reg;
                BSX_NOP1: nop_cycle_reg <= fetch.two_word;
                default: nop_cycle_reg <= 1'b0;
            endcase
        end
    end

    a_write_only_q4: assert property (@(posedge clock) disable iff (!rst_n)
        mem_we_reg |-> phase_reg == 4'h8 && dec_reg.set_register_bit)
        else $error("register write outside q4 or not a set");
    a_set_bit_one: assert property (@(posedge clock) disable iff (!rst_n)
        mem_we_reg |-> wdata_reg[dec_reg.bitpos])
        else $error("selected bit not set");
    // read data still holds the old register value in q4
    a_others_kept: assert property (@(posedge clock) disable iff (!rst_n)
        mem_we_reg |-> (wdata_reg & ~(8'h01 << dec_reg.bitpos))
            == (rdata & ~(8'h01 << dec_reg.bitpos)))
        else $error("other bits changed");
    a_no_flags: assert property (@(posedge clock) disable iff (!rst_n)
        !status_we_reg)
        else $error("status written");
    a_set_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
        (phase_q == BSX_Q3 && state_reg == BSX_EXEC && dec_reg.set_register_bit)
        |=> mem_we_reg ##1 !mem_we_reg)
        else $error("set-bit write not a single q4 pulse");
    a_skip_nop: assert property (@(posedge clock) disable iff (!rst_n)
        (phase_q == BSX_Q4 && state_reg == BSX_EXEC && skip_reg) |=> nop_cycle_reg[*4])
        else $error("skip did not give a nop cycle");
    a_nop_no_write: assert property (@(posedge clock) disable iff (!rst_n)
        nop_cycle_reg |-> !mem_we_reg)
        else $error("write during a discarded cycle");
    a_noskip_set: assert property (@(posedge clock) disable iff (!rst_n)
        (phase_q == BSX_Q3 && state_reg == BSX_EXEC && dec_reg.set_register_bit)
        |=> !skip_reg)
        else $error("set-bit caused skip");
    a_skip_cond: assert property (@(posedge clock) disable iff (!rst_n)
        (phase_q == BSX_Q3 && state_reg == BSX_EXEC && dec_reg.test_bit_skip_when_clear)
        |=> skip_reg == !$past(rdata[dec_reg.bitpos]))
        else $error("skip decision wrong");
    a_two_word: assert property (@(posedge clock) disable iff (!rst_n)
        (phase_q == BSX_Q4 && state_reg == BSX_NOP1 && fetch.two_word)
        |=> state_reg == BSX_NOP2 ##4 state_reg == BSX_EXEC)
        else $error("two-word skip length wrong");
    a_access_bank: assert property (@(posedge clock) disable iff (!rst_n)
        (phase_q == BSX_Q2 && !dec_reg.bank_sel)
        |=> addr_reg[AW-1:8] == ($past(dec_reg.faddr[7]) ? 4'hf : 4'h0))
        else $error("access bank address wrong");
endmodule

// file: bench/bsx_fetch_model.sv
// Purpose: fetch side model that offers instruction words to the block
// Assumes: the bench holds each word until the block takes it
// Notes: the prefetched word stands through the first discarded cycle only; the block must ignore it
`timescale 1ns/1ps
module bsx_fetch_model
    import bsx_pkg::*;
(
    input wire logic [15:0] next_word,
    input wire logic next_two,
    output bsx_fetch_t fetch
);
    always_comb begin
        fetch.word = next_word;
        fetch.two_word = next_two;
    end
endmodule

// file: bench/tb_bit_set_and_test_skip_exec.sv
// Purpose: self-checking bench for the bit set / test-skip block
// Assumes: the bench clears the data memory at time zero, so every bit is known
// Notes: the word behind a test is a set, so a wrongly kept prefetch shows as a write
`timescale 1ns/1ps
module tb_bit_set_and_test_skip_exec
    import bsx_pkg::*;
;
    localparam logic [20:0] BANK_TAB [4] = '{{1'b0, 8'h7f, 12'h07f}, {1'b0, 8'h80, 12'hf80},
                                             {1'b1, 8'h20, 12'h320}, {1'b1, 8'h80, 12'h380}};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] next_word = 16'h0000;
    logic next_two = 1'b0;
    logic [3:0] bank_pointer = 4'h0;
    bsx_fetch_t fetch;
    logic [3:0] phase_reg;
    logic skip_reg, nop_cycle_reg, status_we_reg, mem_we_reg;
    logic [11:0] addr_reg;
    logic [7:0] wdata_reg;
    int err_count = 0;
    int n_checks = 0;

    always #50 clock = ~clock;

    bsx_fetch_model u_fetch (.next_word(next_word), .next_two(next_two), .fetch(fetch));
    bsx_exec #(.AW(12)) DUT (.clock(clock), .rst_n(rst_n), .fetch(fetch),
        .bank_pointer(bank_pointer), .phase_reg(phase_reg), .skip_reg(skip_reg),
        .nop_cycle_reg(nop_cycle_reg), .status_we_reg(status_we_reg), .addr_reg(addr_reg),
        .wdata_reg(wdata_reg), .mem_we_reg(mem_we_reg));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // offers a word, waits for the taking edge, returns in the settled q4 phase
    task automatic issue(input logic [15:0] w, input logic two);
        int k;
        @(posedge clock);
        next_word <= w;
        next_two <= two;
        @(negedge clock);
        for (k = 0; k < 12 && (phase_reg !== BSX_Q1 || nop_cycle_reg !== 1'b0); k++)
            @(negedge clock);
        check("take_wait", 16'(k < 12), 16'h0001);
        @(posedge clock);
        next_word <= 16'h0000;
        repeat (3) @(negedge clock);
    endtask

    task automatic set_bits();
        logic [7:0] exp;
        exp = 8'h00;
        for (int b = 0; b < 8; b++) begin
            issue({4'h8, 3'(b), 1'b0, 8'h10}, 1'b0);
            exp[b] = 1'b1;
            check("mem_we", 16'(mem_we_reg), 16'h0001);
            check("wdata", 16'(wdata_reg), 16'(exp));
            check("addr", 16'(addr_reg), 16'h0010);
            check("status_we", 16'(status_we_reg), 16'h0000);
            @(negedge clock);
            check("one_cycle", 16'({mem_we_reg, phase_reg}), 16'h0001);
        end
    endtask

    task automatic bank_select();
        for (int i = 0; i < 4; i++) begin
            issue({4'h8, 3'h0, BANK_TAB[i][20:12]}, 1'b0);
            check("bank_addr", 16'(addr_reg), 16'(BANK_TAB[i][11:0]));
        end
    endtask

    task automatic test_skip(input logic [7:0] f, input logic two, input logic known_set);
        int nops;
        int writes;
        logic skipped;
        logic [15:0] exp_nops;
        nops = 0;
        writes = 0;
        exp_nops = known_set ? 16'h0000 : (two ? 16'h0008 : 16'h0004);
        issue({4'hb, 3'h2, 1'b0, f}, two);
        skipped = skip_reg;
        // the prefetch behind the test sets bit 7 of 0x040; a skip must drop it
        for (int c = 0; c < 8; c++) begin
            @(posedge clock);
            if (c == 0)
                next_word <= 16'h8e40;
            if (c == 4)
                next_word <= 16'h0000;
            @(negedge clock);
            nops += int'(nop_cycle_reg === 1'b1);
            writes += int'(mem_we_reg === 1'b1);
        end
        check("skip", 16'(skipped), 16'(!known_set));
        check("nop_run", 16'(nops), exp_nops);
        check("prefetch_write", 16'(writes), 16'(known_set));
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clock);
        err_count++;
        print_verdict();
    end

    initial begin
        // the data memory has no reset; clear it so every tested bit is known
        for (int i = 0; i < 4096; i++)
            DUT.u_mem.mem[i] = 8'h00;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        bank_pointer <= 4'h3;
        set_bits();
        bank_select();
        test_skip(8'h10, 1'b0, 1'b1);
        test_skip(8'h50, 1'b0, 1'b0);
        test_skip(8'h51, 1'b1, 1'b0);
        print_verdict();
    end
endmodule
